/* File: inc/seq_pkg.sv */
`default_nettype none
package seq_pkg;

	// ************************************************************
	// Timing.
	// ************************************************************
	localparam int CLK_HZ = 25000000;
	localparam int OFFSET_TO_BIAS_DELAY_MIN_US = 1000;
	localparam int OFFSET_TO_BIAS_DELAY_NOM_US = 2000;
	localparam int ENABLE_TO_GOOD_HOLD_NS = 100;
	localparam int CLK_PERIOD_NS = 40;
	localparam int OFFSET_TO_BIAS_CYCLES = OFFSET_TO_BIAS_DELAY_NOM_US * (CLK_HZ / 1000000);
	localparam int HOLD_CYCLES = (ENABLE_TO_GOOD_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DISCHARGE_CYCLES = 2500;
	localparam int LOGIC_SETTLE_CYCLES = 2500;

	// ************************************************************
	// Register map.
	// ************************************************************
	localparam logic [11:0] CTRL_OFFSET = 12'h000;
	localparam logic [11:0] STATUS_OFFSET = 12'h004;
	localparam int CTRL_START_BIT = 0;
	localparam int CTRL_STOP_BIT = 1;
	localparam int CTRL_EMERG_BIT = 2;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;

	typedef enum logic [3:0] {
		ST_OFF, ST_LOGIC_ON, ST_OFFSET_ON, ST_DELAY, ST_HV_ON, ST_GLOBAL_BIAS, ST_RUN,
		ST_PARK, ST_PWRDN, ST_HOLD, ST_DISCHARGE, ST_EPARK
	} seq_state_t;

	typedef struct packed {
		logic logic_supply_en;
		logic offset_supply_en;
		logic bias_supply_en;
		logic mirror_reset_supply_en;
		logic power_down_n;
		logic reset_output_enable_n;
		logic global_bias_cmd;
		logic park_req;
	} dev_ctl_t;

	typedef struct packed {
		logic logic_supply_good;
		logic offset_supply_good;
		logic park_done;
		logic park_done_output_enable_n;
		logic rails_discharged;
		logic power_loss;
	} dev_stat_t;

endpackage
`default_nettype wire

/* File: hdl/delay_counter.sv */
`timescale 1ns/1ps
`default_nettype none
module delay_counter (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic load,
	input wire logic [31:0] count,
	output logic done
);
	logic [31:0] remaining;

	// Loads a count and signals done once it has run down.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			remaining <= 32'h00000000;
			done <= 1'b0;
		end else if (ce) begin
			if (load) begin
				remaining <= count;
				done <= 1'b0;
			end else if (remaining > 32'h00000001) begin
				remaining <= remaining - 32'h00000001;
			end else begin
				remaining <= 32'h00000000;
				done <= 1'b1;
			end
		end
	end
endmodule
`default_nettype wire

/* File: hdl/mirror_array_power_sequencer.sv */
// Functional notes
// - Logic supply settles before other supplies.
// - Wait nominal 2 ms offset-to-bias.
// - Offset good held 100 ns after disable.
// - No reset-versus-bias supply ordering needed.
// - CMOS inputs low until logic settles.
// - Logic supply stays until rails discharge.
// - High voltage only after reset enable high.
// - Issue global bias after high voltage.
// - Park, then power-down, then disable supplies; offset, bias and mirror reset drop with power-down.
// - Emergency park; enable may drop late.
`timescale 1ns/1ps
`default_nettype none
module mirror_array_power_sequencer #(
	parameter int OFFSET_TO_BIAS_CYCLES = seq_pkg::OFFSET_TO_BIAS_CYCLES
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire seq_pkg::dev_stat_t dev_stat,
	output seq_pkg::dev_ctl_t dev_ctl,
	output logic cmos_inputs_enable
);

	// ************************************************************
	// Register bus.
	// ************************************************************
	seq_pkg::seq_state_t state;
	logic start_req;
	logic stop_req;
	logic emerg_req;
	logic bus_access;
	logic offset_good_seen_after_disable;

	assign bus_access = psel && penable;

	// Answers every access in its first access cycle; writes latch one-shot requests.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
			start_req <= 1'b0;
			stop_req <= 1'b0;
			emerg_req <= 1'b0;
		end else if (ce) begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				if (paddr == seq_pkg::CTRL_OFFSET) begin
					prdata <= seq_pkg::CTRL_RESET;
				end else if (paddr == seq_pkg::STATUS_OFFSET) begin
					prdata <= {20'h00000, offset_good_seen_after_disable, dev_stat.power_loss,
						dev_stat.rails_discharged, dev_stat.park_done, dev_stat.offset_supply_good,
						dev_stat.logic_supply_good, 2'h0, 4'(state)};
				end else begin
					prdata <= 32'h00000000;
					pslverr <= 1'b1;
				end
			end
			if (bus_access && pready && pwrite && paddr == seq_pkg::CTRL_OFFSET) begin
				start_req <= pwdata[seq_pkg::CTRL_START_BIT];
				stop_req <= pwdata[seq_pkg::CTRL_STOP_BIT];
				emerg_req <= pwdata[seq_pkg::CTRL_EMERG_BIT];
			end else begin
				start_req <= 1'b0;
				stop_req <= 1'b0;
				emerg_req <= emerg_req && state == seq_pkg::ST_RUN;
			end
		end
	end

	// ************************************************************
	// Timer.
	// ************************************************************
	logic timer_load;
	logic [31:0] timer_count;
	logic timer_done;
	seq_pkg::seq_state_t next_state;

	delay_counter u_timer (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.load(timer_load),
		.count(timer_count),
		.done(timer_done)
	);

	// Reloads the timer whenever the sequencer enters a timed state.
	always_comb begin
		timer_load = (next_state != state);
		case (next_state)
			seq_pkg::ST_LOGIC_ON: timer_count = 32'(seq_pkg::LOGIC_SETTLE_CYCLES);
			seq_pkg::ST_DELAY: timer_count = 32'(OFFSET_TO_BIAS_CYCLES);
			seq_pkg::ST_HOLD: timer_count = 32'(seq_pkg::HOLD_CYCLES);
			seq_pkg::ST_DISCHARGE: timer_count = 32'(seq_pkg::DISCHARGE_CYCLES);
			default: timer_count = 32'h00000001;
		endcase
	end

	// ************************************************************
	// Sequencer.
	// ************************************************************
	// Chooses the next step of the power sequence.
	always_comb begin
		next_state = state;
		case (state)
			seq_pkg::ST_OFF: begin
				if (start_req) begin
					next_state = seq_pkg::ST_LOGIC_ON;
				end
			end
			seq_pkg::ST_LOGIC_ON: begin
				if (timer_done && dev_stat.logic_supply_good) begin
					next_state = seq_pkg::ST_OFFSET_ON;
				end
			end
			seq_pkg::ST_OFFSET_ON: begin
				if (dev_stat.offset_supply_good) begin
					next_state = seq_pkg::ST_DELAY;
				end
			end
			seq_pkg::ST_DELAY: begin
				if (timer_done) begin
					next_state = seq_pkg::ST_HV_ON;
				end
			end
			seq_pkg::ST_HV_ON: next_state = seq_pkg::ST_GLOBAL_BIAS;
			seq_pkg::ST_GLOBAL_BIAS: next_state = seq_pkg::ST_RUN;
			seq_pkg::ST_RUN: begin
				if (emerg_req || dev_stat.power_loss) begin
					next_state = seq_pkg::ST_EPARK;
				end else if (stop_req) begin
					next_state = seq_pkg::ST_PARK;
				end
			end
			seq_pkg::ST_PARK: begin
				if (dev_stat.park_done) begin
					next_state = seq_pkg::ST_PWRDN;
				end
			end
			seq_pkg::ST_PWRDN: next_state = seq_pkg::ST_HOLD;
			seq_pkg::ST_HOLD: begin
				if (timer_done) begin
					next_state = seq_pkg::ST_DISCHARGE;
				end
			end
			seq_pkg::ST_DISCHARGE: begin
				if (timer_done && dev_stat.rails_discharged) begin
					next_state = seq_pkg::ST_OFF;
				end
			end
			seq_pkg::ST_EPARK: begin
				if (dev_stat.park_done_output_enable_n) begin
					next_state = seq_pkg::ST_PWRDN;
				end
			end
			default: next_state = seq_pkg::ST_OFF;
		endcase
	end

	// Holds the sequencer state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= seq_pkg::ST_OFF;
		end else if (ce) begin
			state <= next_state;
		end
	end

	// ************************************************************
	// Device pins.
	// ************************************************************
	// Drives supply enables and control pins from the next state.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			dev_ctl <= '0;
			cmos_inputs_enable <= 1'b0;
		end else if (ce) begin
			dev_ctl.logic_supply_en <= next_state != seq_pkg::ST_OFF;
			cmos_inputs_enable <= next_state != seq_pkg::ST_OFF && next_state != seq_pkg::ST_LOGIC_ON
				&& next_state != seq_pkg::ST_DISCHARGE;
			dev_ctl.reset_output_enable_n <= next_state != seq_pkg::ST_OFF && next_state != seq_pkg::ST_LOGIC_ON;
			// The offset enable trails the reset enable by a cycle, so the reset enable is already high.
			dev_ctl.offset_supply_en <= dev_ctl.reset_output_enable_n
				&& next_state inside {seq_pkg::ST_OFFSET_ON, seq_pkg::ST_DELAY, seq_pkg::ST_HV_ON,
				seq_pkg::ST_GLOBAL_BIAS, seq_pkg::ST_RUN, seq_pkg::ST_PARK, seq_pkg::ST_EPARK};
			dev_ctl.bias_supply_en <= next_state inside {seq_pkg::ST_HV_ON, seq_pkg::ST_GLOBAL_BIAS,
				seq_pkg::ST_RUN, seq_pkg::ST_PARK, seq_pkg::ST_EPARK};
			dev_ctl.mirror_reset_supply_en <= next_state inside {seq_pkg::ST_HV_ON, seq_pkg::ST_GLOBAL_BIAS,
				seq_pkg::ST_RUN, seq_pkg::ST_PARK, seq_pkg::ST_EPARK};
			dev_ctl.global_bias_cmd <= next_state == seq_pkg::ST_GLOBAL_BIAS;
			dev_ctl.park_req <= next_state == seq_pkg::ST_PARK || next_state == seq_pkg::ST_EPARK;
			dev_ctl.power_down_n <= !(next_state inside {seq_pkg::ST_PWRDN, seq_pkg::ST_HOLD,
				seq_pkg::ST_DISCHARGE, seq_pkg::ST_OFF});
		end
	end

	// Flags an offset good indication that dropped before its hold time ran out.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offset_good_seen_after_disable <= 1'b0;
		end else if (ce) begin
			if (state == seq_pkg::ST_HOLD && !timer_done && !dev_stat.offset_supply_good) begin
				offset_good_seen_after_disable <= 1'b1;
			end else if (start_req) begin
				offset_good_seen_after_disable <= 1'b0;
			end
		end
	end

	// ************************************************************
	// Assertions.
	// ************************************************************
	sequence hv_rise_s;
		$rose(dev_ctl.bias_supply_en);
	endsequence

	AST_LOGIC_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(dev_ctl.offset_supply_en) |-> dev_ctl.logic_supply_en)
		else $error("offset enabled without logic supply");
	AST_DELAY_DONE: assert property (@(posedge pclk) disable iff (!presetn)
		hv_rise_s |-> $past(state) == seq_pkg::ST_DELAY || $past(state) == seq_pkg::ST_HV_ON)
		else $error("bias enabled without offset delay");
	AST_HOLD_ORDER: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(dev_ctl.offset_supply_en) && state == seq_pkg::ST_PWRDN |-> !dev_ctl.power_down_n)
		else $error("offset dropped before power down");
	AST_CMOS_LOW: assert property (@(posedge pclk) disable iff (!presetn)
		cmos_inputs_enable |-> dev_ctl.logic_supply_en)
		else $error("cmos inputs driven without logic supply");
	AST_LOGIC_LAST: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(dev_ctl.logic_supply_en) |-> !dev_ctl.offset_supply_en && !dev_ctl.bias_supply_en)
		else $error("logic supply off before rails");
	AST_HV_AFTER_OE: assert property (@(posedge pclk) disable iff (!presetn)
		dev_ctl.offset_supply_en |-> dev_ctl.reset_output_enable_n && $past(dev_ctl.reset_output_enable_n))
		else $error("high voltage without reset enable");
	AST_GLOBAL_BIAS: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		hv_rise_s |=> dev_ctl.global_bias_cmd)
		else $error("global bias not issued");
	AST_PARK_FIRST: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(dev_ctl.power_down_n) |-> $past(dev_ctl.park_req))
		else $error("power down before park");
	AST_EPARK: assert property (@(posedge pclk) disable iff (!presetn || !ce)
		state == seq_pkg::ST_EPARK && !dev_stat.park_done_output_enable_n
		|=> dev_ctl.offset_supply_en && dev_ctl.park_req)
		else $error("emergency park left early");

endmodule
`default_nettype wire

/* File: sim/array_device_model.sv */
`timescale 1ns/1ps
`default_nettype none
module array_device_model (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [3:0] lat,
	input wire logic power_loss,
	input wire logic early_drop,
	input wire seq_pkg::dev_ctl_t dev_ctl,
	output seq_pkg::dev_stat_t dev_stat
);
	logic [3:0] c_log;
	logic [3:0] c_off;
	logic [3:0] c_hold;
	logic [3:0] c_park;
	logic [5:0] c_dis;
	logic og;
	logic pd;
	// ************************************************************
	// Supply and mirror behaviour.
	// ************************************************************
	// Logic good comes lat cycles after enable, offset good one cycle later; offset good lingers five cycles after disable, two if early_drop.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_log <= '0;
			c_off <= '0;
			c_hold <= '0;
			og <= 1'b0;
		end else begin
			c_log <= !dev_ctl.logic_supply_en ? 4'h0 : (c_log == 4'hF ? c_log : c_log + 4'h1);
			if (dev_ctl.offset_supply_en) begin
				c_off <= (c_off == 4'hF) ? c_off : c_off + 4'h1;
				og <= (c_off >= lat);
				c_hold <= 4'h0;
			end else begin
				c_off <= 4'h0;
				c_hold <= (c_hold == 4'hF) ? c_hold : c_hold + 4'h1;
				if (c_hold == (early_drop ? 4'h1 : 4'h4)) og <= 1'b0;
			end
		end
	end
	// Parking finishes lat+1 cycles after the request; rails drain 32 cycles after the offset, bias and mirror reset supplies are off and offset good drops.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			c_park <= '0;
			pd <= 1'b0;
			c_dis <= '0;
		end else begin
			c_park <= !dev_ctl.park_req ? 4'h0 : (c_park == 4'hF ? c_park : c_park + 4'h1);
			if (!dev_ctl.logic_supply_en) pd <= 1'b0;
			else if (dev_ctl.park_req && c_park >= lat) pd <= 1'b1;
			if (dev_ctl.offset_supply_en | dev_ctl.bias_supply_en | dev_ctl.mirror_reset_supply_en | og) c_dis <= '0;
			else if (c_dis != 6'h3F) c_dis <= c_dis + 6'h01;
		end
	end
	// Status levels seen by the controller.
	always_comb begin
		dev_stat.logic_supply_good = dev_ctl.logic_supply_en && (c_log >= lat);
		dev_stat.offset_supply_good = og;
		dev_stat.park_done = pd;
		dev_stat.park_done_output_enable_n = pd;
		dev_stat.rails_discharged = (c_dis >= 6'h20);
		dev_stat.power_loss = power_loss;
	end
endmodule
`default_nettype wire

/* File: sim/mirror_array_power_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module mirror_array_power_sequencer_tb;
	localparam int P = 4;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cmos_inputs_enable, pl, e, ce, drop;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [3:0] lat;
	seq_pkg::dev_ctl_t dev_ctl, pc;
	seq_pkg::dev_stat_t dev_stat;
	int n_mismatch = 0;
	int checks = 0;
	int since_og = 0;
	int n_gb = 0;
	mirror_array_power_sequencer #(.OFFSET_TO_BIAS_CYCLES(P)) dut (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .dev_stat(dev_stat), .dev_ctl(dev_ctl),
		.cmos_inputs_enable(cmos_inputs_enable));
	array_device_model model (.pclk(pclk), .presetn(presetn), .lat(lat), .power_loss(pl), .early_drop(drop),
		.dev_ctl(dev_ctl), .dev_stat(dev_stat));
	// Works out whether a run's shutdown should leave the early-drop flag set.
	function automatic logic exp_drop(input int m);
		return m == 1;
	endfunction
	// ************************************************************
	// Tasks.
	// ************************************************************
	// Counts one comparison and reports a mismatch.
	task automatic chk(input logic ok, input string m);
		checks++;
		if (ok !== 1'b1) begin
			n_mismatch++;
			$display("[ERR] %0t %s", $time, m);
		end
	endtask
	// One APB transfer, then one idle cycle.
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// Polls the state field until it matches.
	task automatic wait_state(input logic [3:0] s);
		int i = 0;
		q = 32'hFFFFFFFF;
		while (q[3:0] !== s && i < 4000) begin
			apb(1'b0, seq_pkg::STATUS_OFFSET, 32'h00000000);
			i++;
		end
		chk(q[3:0] === s, "state not reached");
	endtask
	// Prints the counts and the verdict.
	task automatic summarize();
		$display("n_mismatch=%0d checks=%0d", n_mismatch, checks);
		if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// ************************************************************
	// Pin monitor.
	// ************************************************************
	// Watches ordering of the control pins against the device status.
	always @(posedge pclk) begin
		pc <= dev_ctl;
		since_og <= (dev_stat.offset_supply_good === 1'b1) ? since_og + 1 : 0;
		if (presetn === 1'b1) begin
			if (dev_ctl.global_bias_cmd === 1'b1) n_gb <= n_gb + 1;
			if ((dev_ctl.offset_supply_en | dev_ctl.bias_supply_en | dev_ctl.mirror_reset_supply_en) === 1'b1 &&
				(pc.offset_supply_en | pc.bias_supply_en | pc.mirror_reset_supply_en) === 1'b0)
				chk(dev_stat.logic_supply_good & dev_ctl.reset_output_enable_n & pc.reset_output_enable_n,
					"early supply");
			if (cmos_inputs_enable === 1'b1 && pc.logic_supply_en === 1'b0) chk(1'b0, "cmos early");
			if (cmos_inputs_enable === 1'b1) chk(dev_stat.logic_supply_good, "cmos before logic good");
			if (dev_ctl.bias_supply_en === 1'b1 && pc.bias_supply_en === 1'b0) chk(since_og >= P, "bias early");
			if (dev_ctl.global_bias_cmd === 1'b1) chk(pc.bias_supply_en & dev_ctl.bias_supply_en, "bias cmd");
			if (pc.power_down_n === 1'b1 && dev_ctl.power_down_n === 1'b0)
				chk((dev_stat.park_done | dev_stat.park_done_output_enable_n) & !dev_ctl.offset_supply_en &
					!dev_ctl.bias_supply_en & !dev_ctl.mirror_reset_supply_en, "power down order");
			if (pc.logic_supply_en === 1'b1 && dev_ctl.logic_supply_en === 1'b0)
				chk(dev_stat.rails_discharged & !dev_ctl.offset_supply_en, "logic off early");
		end
	end
	// ************************************************************
	// Stimulus.
	// ************************************************************
	// Makes the clock.
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	// Cuts a hang short.
	initial begin
		#(40 * 80000);
		n_mismatch++;
		summarize();
	end
	// Main sequence: reset, register checks, three power cycles with three shutdown kinds.
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h00000000;
		lat = 4'h2;
		pl = 1'b0;
		ce = 1'b1;
		drop = 1'b0;
		void'($urandom(32'hD6976A52));
		repeat (20) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(dev_ctl === '0 && cmos_inputs_enable === 1'b0, "reset outputs");
		apb(1'b0, 12'h0F0, 32'h00000000);
		chk(e === 1'b1 && q === 32'h00000000, "unmapped read");
		apb(1'b0, seq_pkg::CTRL_OFFSET, 32'h00000000);
		chk(e === 1'b0 && q === 32'h00000000, "ctrl read");
		// An emergency request while off must not linger into the next run.
		apb(1'b1, seq_pkg::CTRL_OFFSET, 32'h00000004);
		for (int m = 0; m < 3; m++) begin
			lat <= 4'($urandom_range(1, 9));
			repeat ($urandom_range(0, 5)) @(posedge pclk);
			apb(1'b1, seq_pkg::CTRL_OFFSET, 32'h00000001);
			wait_state(4'(seq_pkg::ST_RUN));
			chk(n_gb === m + 1, "bias command count");
			chk(q[7:6] === 2'h3, "status good bits");
			if (m == 0) begin
				ce <= 1'b0;
				pl <= 1'b1;
				repeat (8) @(posedge pclk);
				chk(dev_ctl.park_req === 1'b0 && dev_ctl.bias_supply_en === 1'b1, "clock enable freeze");
				ce <= 1'b1;
				pl <= 1'b0;
			end
			repeat (10) @(posedge pclk);
			apb(1'b0, seq_pkg::STATUS_OFFSET, 32'h00000000);
			chk(q[3:0] === 4'(seq_pkg::ST_RUN), "run left early");
			drop <= exp_drop(m);
			if (m == 2) pl <= 1'b1;
			else apb(1'b1, seq_pkg::CTRL_OFFSET, (m == 0) ? 32'h00000002 : 32'h00000004);
			wait_state(4'(seq_pkg::ST_OFF));
			chk(q[11] === exp_drop(m) && dev_ctl.logic_supply_en === 1'b0, "shutdown end");
			pl <= 1'b0;
			drop <= 1'b0;
		end
		summarize();
	end
endmodule
`default_nettype wire
